// file: include/perg_pkg.sv
// package for the profiling event record generator
package perg_pkg;
    localparam logic [7:0] EVT_CORE_CLK = 8'h05;
    localparam logic [7:0] EVT_REF_CLK = 8'h06;
    localparam logic [7:0] EVT_USER = 8'hff;
    // capability query leaves and subleaves
    localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
    localparam logic [31:0] LEAF_XSTATE = 32'h0000_000d;
    localparam logic [31:0] LEAF_EXT = 32'h8000_0001;
    localparam logic [31:0] LEAF_PROF = 32'h8000_001c;
    localparam logic [31:0] SUB_ZERO = 32'h0000_0000;
    localparam logic [31:0] SUB_PROF = 32'h0000_003e;
    localparam int BIT_EXT_PROF = 15;
    localparam int BIT_XSTATE_EDX_PROF = 30;
    localparam int BIT_EXTENDED_STATE_SAVE_SUP = 26;
    localparam int BIT_MASK_PROF = 62;
    localparam int BIT_CORE_AVAIL = 5;
    localparam int BIT_REF_AVAIL = 6;
    localparam logic [31:0] PROF_SAVE_SIZE = 32'h0000_0080;
    localparam logic [31:0] PROF_SAVE_OFFSET = 32'h0000_0340;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CORE_ID = 4'h1;
    localparam logic [3:0] REG_CORE_IVL = 4'h2;
    localparam logic [3:0] REG_REF_IVL = 4'h3;
    localparam logic [3:0] REG_REF_RATIO = 4'h4;
    localparam logic [3:0] REG_ENA_LO = 4'h5;
    localparam logic [3:0] REG_ENA_HI = 4'h6;
    localparam logic [3:0] REG_CORE_CNT = 4'h7;
    localparam logic [3:0] REG_REF_CNT = 4'h8;
    localparam logic [3:0] REG_BASE_SIZE = 4'h9;
    localparam int CTRL_CORE_EN = 0;
    localparam int CTRL_REF_EN = 1;
    localparam int CTRL_TS_EN = 2;
    localparam int FRAC_BITS = 16;

    // one 32-byte record as four quadwords
    typedef struct packed {
        logic [63:0] timestamp;
        logic [63:0] register_value_field;
        logic [63:0] instr_pointer_field;
        logic [31:0] operand_value_field;
        logic [15:0] flags;
        logic [7:0] core_id;
        logic [7:0] event_identifier;
    } perg_record_s;

    // insert-user-record instruction operands
    typedef struct packed {
        logic valid;
        logic [15:0] imm;
        logic [31:0] rm_value;
        logic [63:0] reg_value;
        logic [63:0] ip;
    } perg_user_s;

    // capability query answer
    typedef struct packed {
        logic [31:0] eax;
        logic [31:0] ebx;
        logic [31:0] ecx;
        logic [31:0] edx;
    } perg_cap_s;
endpackage

// file: verilog/perg_top.sv
// profiling event record generator with capability query answers
// What this block does
// - core counter decrements each non-halted core clock
// - core counter going negative writes record with identifier 5
// - reference counter decrements each non-halted reference tick
// - reference counter going negative writes record with identifier 6
// - reference tick may be a ratio accumulated every non-halted core clock
// - counter records: id byte 0, ip bytes 8-15, bytes 2-7 and 16-23 zero
// - byte 1 of every record holds configured core identifier
// - bytes 24-31 hold timestamp when enabled, else zero
// - insert-user-record instruction writes record with identifier 255
// - user record: flags from immediate, bytes 4-7 from reg/mem operand
// - user record bytes 8-15 carry its own instruction address
// - user record bytes 16-23 hold register value, zero extended in legacy
// - presence bit 15 set in extended leaf ecx
// - presence equals xstate leaf edx bit 30 (mask bit 62)
// - presence implies save support bit 26 in basic leaf ecx
// - profiler subleaf returns save size 128 in eax
// - profiler subleaf returns save offset 832 in ebx
// - max supported save size always includes profiler area
// - max enabled save size includes profiler area only when enabled
// - profiler leaf bits 5 and 6 show core and reference events
`timescale 1ns/1ps
`default_nettype none
module perg_top #(
    parameter int CNT_W = 32,
    parameter logic [31:0] BASE_SAVE_SIZE = 32'h0000_0340
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // core status
    input wire logic stop_clock_request_i,
    input wire logic halt_instruction_i,
    input wire logic legacy_mode_i,
    input wire logic [63:0] instr_ptr_i,
    input wire logic [63:0] timestamp_i,
    input wire perg_pkg::perg_user_s user_i,
    // record output
    output perg_pkg::perg_record_s rec_o,
    output logic rec_valid_o,
    // capability query
    input wire logic cap_req_i,
    input wire logic [31:0] cap_leaf_i,
    input wire logic [31:0] cap_sub_i,
    output perg_pkg::perg_cap_s cap_o,
    output logic cap_valid_o
);
    import perg_pkg::*;

    // elaboration check: counters and their reads must fit one 32-bit word
    // a one-bit counter would have no room left for its sign
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
        $error("CNT_W must be between 2 and 32");
    end

    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] core_id;
        logic [CNT_W-1:0] core_ivl;
        logic [CNT_W-1:0] ref_ivl;
        logic [31:0] ref_ratio;
        logic [63:0] ena_mask;
        logic [CNT_W-1:0] core_cnt;
        logic [CNT_W-1:0] ref_cnt;
        logic [FRAC_BITS-1:0] ref_frac;
        logic core_pend;
        logic ref_pend;
        logic [31:0] rdata;
        perg_record_s rec;
        logic rec_valid;
        perg_cap_s cap;
        logic cap_valid;
    } perg_state_s;

    perg_state_s s_q;
    perg_state_s s_d;

    // common record fields: identifier, core id, ip, timestamp
    function automatic perg_record_s base_rec(input logic [7:0] id, input logic [7:0] cid,
                                              input logic [63:0] ip, input logic ts_en,
                                              input logic [63:0] ts);
        perg_record_s r;
        r = '0;
        r.event_identifier = id;
        r.core_id = cid;
        r.instr_pointer_field = ip;
        r.timestamp = ts_en ? ts : 64'h0;
        return r;
    endfunction

    // halt status, reference tick and sign of each counter
    logic running;
    logic [FRAC_BITS:0] frac_sum;
    logic ref_tick;
    logic core_neg;
    logic ref_neg;
    logic [CNT_W-1:0] one_cnt;
    assign one_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
    assign running = !stop_clock_request_i && !halt_instruction_i;
    // reference tick from fractional ratio accumulated per core clock
    assign frac_sum = {1'b0, s_q.ref_frac} + {1'b0, s_q.ref_ratio[FRAC_BITS-1:0]};
    assign ref_tick = running && frac_sum[FRAC_BITS];
    assign core_neg = s_q.core_cnt[CNT_W-1];
    assign ref_neg = s_q.ref_cnt[CNT_W-1];

    // next state: registers, counters, records, capability answers
    always_comb begin
        s_d = s_q;
        s_d.rec_valid = 1'b0;
        s_d.cap_valid = 1'b0;
        s_d.rdata = RESET_WORD;
        // counting, a pending counter is frozen until its record goes out
        if (running && s_q.ctrl[CTRL_CORE_EN] && !s_q.core_pend) begin
            s_d.core_cnt = s_q.core_cnt - one_cnt;
            if (s_d.core_cnt[CNT_W-1]) begin
                s_d.core_pend = 1'b1;
            end
        end
        // the fraction keeps running while a record waits, but a tick landing while ref_pend is set is not counted
        if (running) begin
            s_d.ref_frac = frac_sum[FRAC_BITS-1:0];
        end
        if (ref_tick && s_q.ctrl[CTRL_REF_EN] && !s_q.ref_pend) begin
            s_d.ref_cnt = s_q.ref_cnt - one_cnt;
            if (s_d.ref_cnt[CNT_W-1]) begin
                s_d.ref_pend = 1'b1;
            end
        end
        // record emission, user record first, then core, then reference
        if (user_i.valid) begin
            s_d.rec = base_rec(EVT_USER, s_q.core_id, user_i.ip,
                               s_q.ctrl[CTRL_TS_EN], timestamp_i);
            s_d.rec.flags = user_i.imm;
            s_d.rec.operand_value_field = user_i.rm_value;
            s_d.rec.register_value_field = legacy_mode_i ?
                {32'h0, user_i.reg_value[31:0]} : user_i.reg_value;
            s_d.rec_valid = 1'b1;
        end else if (s_q.core_pend) begin
            s_d.rec = base_rec(EVT_CORE_CLK, s_q.core_id, instr_ptr_i,
                               s_q.ctrl[CTRL_TS_EN], timestamp_i);
            s_d.rec_valid = 1'b1;
            s_d.core_pend = 1'b0;
            s_d.core_cnt = s_q.core_ivl;
        end else if (s_q.ref_pend) begin
            s_d.rec = base_rec(EVT_REF_CLK, s_q.core_id, instr_ptr_i,
                               s_q.ctrl[CTRL_TS_EN], timestamp_i);
            s_d.rec_valid = 1'b1;
            s_d.ref_pend = 1'b0;
            s_d.ref_cnt = s_q.ref_ivl;
        end
        // register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_CTRL: s_d.ctrl = reg_wdata_i;
                REG_CORE_ID: s_d.core_id = reg_wdata_i[7:0];
                REG_CORE_IVL: begin
                    s_d.core_ivl = reg_wdata_i[CNT_W-1:0];
                    s_d.core_cnt = reg_wdata_i[CNT_W-1:0];
                    s_d.core_pend = 1'b0;
                end
                REG_REF_IVL: begin
                    s_d.ref_ivl = reg_wdata_i[CNT_W-1:0];
                    s_d.ref_cnt = reg_wdata_i[CNT_W-1:0];
                    s_d.ref_pend = 1'b0;
                end
                REG_REF_RATIO: s_d.ref_ratio = reg_wdata_i;
                REG_ENA_LO: s_d.ena_mask[31:0] = reg_wdata_i;
                REG_ENA_HI: s_d.ena_mask[63:32] = reg_wdata_i;
                default: ;
            endcase
        end
        // register reads, unmapped reads return zero
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: s_d.rdata = s_q.ctrl;
                REG_CORE_ID: s_d.rdata = {24'h0, s_q.core_id};
                REG_CORE_IVL: s_d.rdata = 32'(s_q.core_ivl);
                REG_REF_IVL: s_d.rdata = 32'(s_q.ref_ivl);
                REG_REF_RATIO: s_d.rdata = s_q.ref_ratio;
                REG_ENA_LO: s_d.rdata = s_q.ena_mask[31:0];
                REG_ENA_HI: s_d.rdata = s_q.ena_mask[63:32];
                REG_CORE_CNT: s_d.rdata = 32'(s_q.core_cnt);
                REG_REF_CNT: s_d.rdata = 32'(s_q.ref_cnt);
                REG_BASE_SIZE: s_d.rdata = BASE_SAVE_SIZE;
                default: s_d.rdata = RESET_WORD;
            endcase
        end
        // capability query answer one cycle after the request
        if (cap_req_i) begin
            // unknown leaves and subleaves answer all zero
            s_d.cap = '0;
            s_d.cap_valid = 1'b1;
            if (cap_leaf_i == LEAF_EXT) begin
                s_d.cap.ecx[BIT_EXT_PROF] = 1'b1;
            end else if (cap_leaf_i == LEAF_BASIC) begin
                s_d.cap.ecx[BIT_EXTENDED_STATE_SAVE_SUP] = 1'b1;
            end else if (cap_leaf_i == LEAF_XSTATE && cap_sub_i == SUB_ZERO) begin
                s_d.cap.edx[BIT_XSTATE_EDX_PROF] = 1'b1;
                s_d.cap.ecx = BASE_SAVE_SIZE + PROF_SAVE_SIZE;
                s_d.cap.ebx = s_q.ena_mask[BIT_MASK_PROF] ?
                    BASE_SAVE_SIZE + PROF_SAVE_SIZE : BASE_SAVE_SIZE;
            end else if (cap_leaf_i == LEAF_XSTATE && cap_sub_i == SUB_PROF) begin
                s_d.cap.eax = PROF_SAVE_SIZE;
                s_d.cap.ebx = PROF_SAVE_OFFSET;
            end else if (cap_leaf_i == LEAF_PROF) begin
                s_d.cap.edx[BIT_CORE_AVAIL] = 1'b1;
                s_d.cap.edx[BIT_REF_AVAIL] = 1'b1;
                s_d.cap.eax[0] = s_q.ena_mask[BIT_MASK_PROF];
                s_d.cap.eax[BIT_CORE_AVAIL] = s_q.ctrl[CTRL_CORE_EN];
                s_d.cap.eax[BIT_REF_AVAIL] = s_q.ctrl[CTRL_REF_EN];
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o = s_q.rdata;
    assign rec_o = s_q.rec;
    assign rec_valid_o = s_q.rec_valid;
    assign cap_o = s_q.cap;
    assign cap_valid_o = s_q.cap_valid;

    // checks
    // core counter steps once per running cycle
    chk_core_decr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (running && s_q.ctrl[CTRL_CORE_EN] && !s_q.core_pend && !user_i.valid && !reg_wr_i
         && !core_neg) |=> (s_q.core_cnt == $past(s_q.core_cnt) - one_cnt || s_q.core_pend))
        else $error("core counter did not decrement");

    // core counter frozen by either halt cause
    chk_core_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!running && !s_q.core_pend && !reg_wr_i) |=> $stable(s_q.core_cnt))
        else $error("core counter moved while halted");

    // pending core event goes out next cycle
    chk_core_record: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.core_pend && !user_i.valid) |=>
        (rec_valid_o && rec_o.event_identifier == EVT_CORE_CLK))
        else $error("core record missing");

    // pending reference event waits behind the core one
    chk_ref_record: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.ref_pend && !s_q.core_pend && !user_i.valid) |=>
        (rec_valid_o && rec_o.event_identifier == EVT_REF_CLK))
        else $error("reference record missing");

    // user record built from the instruction operands
    chk_user_record: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        user_i.valid |=> (rec_valid_o && rec_o.event_identifier == EVT_USER
                          && rec_o.flags == $past(user_i.imm)
                          && rec_o.instr_pointer_field == $past(user_i.ip)))
        else $error("user record wrong");

    // legacy mode clears the upper register half
    chk_legacy_zext: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (user_i.valid && legacy_mode_i) |=> rec_o.register_value_field[63:32] == 32'h0)
        else $error("legacy register value not zero extended");

    // timestamp field zero while stamping is off
    chk_ts_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (rec_valid_o && !$past(s_q.ctrl[CTRL_TS_EN])) |-> rec_o.timestamp == 64'h0)
        else $error("timestamp not zero");

    // counter records keep flag and register value bytes zero
    chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (rec_valid_o && rec_o.event_identifier != EVT_USER) |->
        (rec_o.flags == 16'h0 && rec_o.register_value_field == 64'h0))
        else $error("reserved bytes not zero");

    // core counter reloaded with its record
    chk_reload: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.core_pend && !user_i.valid && !reg_wr_i) |=> s_q.core_cnt == s_q.core_ivl)
        else $error("core counter not reloaded");

    // profiler subleaf answers size and offset
    chk_prof_size: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_XSTATE && cap_sub_i == SUB_PROF) |=>
        (cap_valid_o && cap_o.eax == PROF_SAVE_SIZE && cap_o.ebx == PROF_SAVE_OFFSET))
        else $error("profiler save area answer wrong");

    // reference counter frozen while halted
    chk_ref_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!running && !s_q.ref_pend && !reg_wr_i) |=> $stable(s_q.ref_cnt))
        else $error("reference counter moved while halted");

    // reference counter steps once per reference tick
    chk_ref_decr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (ref_tick && s_q.ctrl[CTRL_REF_EN] && !s_q.ref_pend && !reg_wr_i)
        |=> s_q.ref_cnt == $past(s_q.ref_cnt) - one_cnt)
        else $error("reference counter did not decrement");

    // reference counter reloaded with its record
    chk_ref_reload: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.ref_pend && !s_q.core_pend && !user_i.valid && !reg_wr_i)
        |=> s_q.ref_cnt == s_q.ref_ivl)
        else $error("reference counter not reloaded");

    // every record carries the configured core identifier
    chk_core_id: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rec_valid_o |-> rec_o.core_id == $past(s_q.core_id))
        else $error("core identifier wrong");

    // timestamp copied while stamping is on
    chk_ts_value: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (rec_valid_o && $past(s_q.ctrl[CTRL_TS_EN]))
        |-> rec_o.timestamp == $past(timestamp_i))
        else $error("timestamp not copied");

    // long-mode user record keeps both operand values whole
    chk_user_data: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (user_i.valid && !legacy_mode_i) |=>
        (rec_o.operand_value_field == $past(user_i.rm_value)
         && rec_o.register_value_field == $past(user_i.reg_value)))
        else $error("user record operands wrong");

    // presence bit in the extended leaf
    chk_presence: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_EXT)
        |=> (cap_valid_o && cap_o.ecx[BIT_EXT_PROF]))
        else $error("presence bit missing");

    // save support reported beside presence
    chk_extended_state_save_bit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_BASIC) |=> cap_o.ecx[BIT_EXTENDED_STATE_SAVE_SUP])
        else $error("save support bit missing");

    // maximum supported size always holds the profiler area
    chk_max_size: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_XSTATE && cap_sub_i == SUB_ZERO) |=>
        (cap_o.edx[BIT_XSTATE_EDX_PROF] && cap_o.ecx == BASE_SAVE_SIZE + PROF_SAVE_SIZE))
        else $error("supported save size wrong");

    // enabled size leaves the area out while the mask bit is clear
    chk_enabled_size: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_XSTATE && cap_sub_i == SUB_ZERO
         && !s_q.ena_mask[BIT_MASK_PROF])
        |=> cap_o.ebx == BASE_SAVE_SIZE)
        else $error("enabled save size wrong");

    // profiler leaf shows both clock events
    chk_event_avail: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cap_req_i && cap_leaf_i == LEAF_PROF) |=>
        (cap_o.edx[BIT_CORE_AVAIL] && cap_o.edx[BIT_REF_AVAIL]))
        else $error("event availability bits missing");

    // scenarios the bench is meant to reach
    cov_core_rec: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rec_valid_o && rec_o.event_identifier == EVT_CORE_CLK);
    cov_ref_rec: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rec_valid_o && rec_o.event_identifier == EVT_REF_CLK);
    cov_user_rec: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rec_valid_o && rec_o.event_identifier == EVT_USER);
    cov_cap_answer: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
        cap_valid_o && cap_o.ebx == PROF_SAVE_OFFSET);
    cov_halted_armed: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !running && s_q.ctrl[CTRL_CORE_EN]);
endmodule
`default_nettype wire

// file: test/perg_ring.sv
// memory ring model that collects the records the block writes
`timescale 1ns/1ps
`default_nettype none
module perg_ring
    import perg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // records arriving from the block
    input wire perg_pkg::perg_record_s rec_i,
    input wire logic rec_valid_i,
    // what a software reader of the ring would see
    output logic [31:0] n_rec_o,
    output perg_pkg::perg_record_s last_o
);
    // each valid record lands in the next slot; only the newest is kept
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            n_rec_o <= 32'h0;
            last_o <= '0;
        end else if (rec_valid_i) begin
            n_rec_o <= n_rec_o + 32'h1;
            last_o <= rec_i;
        end
    end
endmodule
`default_nettype wire

// file: test/test_profiling_event_record_gen.sv
// self-checking bench for the profiling event record generator
`timescale 1ns/1ps
`default_nettype none
module test_profiling_event_record_gen;
    import perg_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_0340;
    localparam logic [63:0] IP = 64'h0000_0040_1000_2000;
    localparam logic [63:0] TS = 64'h1122_3344_5566_7788;
    localparam logic [63:0] RV = 64'hdead_beef_0123_4567;
    logic sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, stop_clock_request_i, halt_instruction_i;
    logic legacy_mode_i, cap_req_i, rec_valid_o, cap_valid_o;
    logic [3:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, cap_leaf_i, cap_sub_i, n_rec;
    logic [63:0] instr_ptr_i, timestamp_i;
    perg_user_s user_i;
    perg_record_s rec_o, last;
    perg_cap_s cap_o;
    int n_fail, n_tests, a, b, c;

    // block under test and the ring it writes into
    perg_top perg_top_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .stop_clock_request_i(stop_clock_request_i),
        .halt_instruction_i(halt_instruction_i), .legacy_mode_i(legacy_mode_i),
        .instr_ptr_i(instr_ptr_i), .timestamp_i(timestamp_i), .user_i(user_i), .rec_o(rec_o),
        .rec_valid_o(rec_valid_o), .cap_req_i(cap_req_i), .cap_leaf_i(cap_leaf_i),
        .cap_sub_i(cap_sub_i), .cap_o(cap_o), .cap_valid_o(cap_valid_o));
    perg_ring perg_ring_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rec_i(rec_o),
        .rec_valid_i(rec_valid_o), .n_rec_o(n_rec), .last_o(last));

    // 125 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] ad, input logic [31:0] wd);
        @(posedge sys_clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= wd;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data is taken in the single cycle after the strobe
    task automatic reg_rd(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(64'(reg_rdata_o), 64'(exp));
    endtask

    task automatic cap_q(input logic [31:0] leaf, input logic [31:0] sub);
        @(posedge sys_clk_i);
        cap_leaf_i <= leaf;
        cap_sub_i <= sub;
        cap_req_i <= 1'b1;
        @(posedge sys_clk_i);
        cap_req_i <= 1'b0;
        #1 chk(64'(cap_valid_o), 64'h1);
    endtask

    // waits for the ring to gain a record, returns the cycles spent
    task automatic wait_rec(output int cyc);
        logic [31:0] n0;
        n0 = n_rec;
        cyc = 0;
        while (n_rec === n0) begin
            @(posedge sys_clk_i);
            #1 cyc++;
            if (cyc > 300) begin
                n_fail++;
                report_and_stop();
            end
        end
    endtask

    task automatic chk_rec(input logic [7:0] id, input logic [63:0] ip, input logic [63:0] rv,
        input logic [31:0] ov, input logic [15:0] fl, input logic ts);
        chk(64'(last.event_identifier), 64'(id));
        chk(64'(last.core_id), 64'h5a);
        chk(64'(last.flags), 64'(fl));
        chk(64'(last.operand_value_field), 64'(ov));
        chk(last.instr_pointer_field, ip);
        chk(last.register_value_field, rv);
        chk(last.timestamp, ts ? TS : 64'h0);
    endtask

    // unmapped and read-only places, then the core identifier
    task automatic t_regs();
        reg_rd(4'ha, 32'h0);
        reg_wr(4'hf, 32'hffff_ffff);
        reg_rd(4'hf, 32'h0);
        reg_wr(REG_BASE_SIZE, 32'h1);
        reg_rd(REG_BASE_SIZE, BASE);
        reg_wr(REG_CORE_ID, 32'h5a);
    endtask

    // every capability leaf, the xstate leaf before and after enabling the save area
    task automatic t_cap();
        cap_q(32'h8000_0001, 32'h0);
        chk(64'(cap_o.ecx[15]), 64'h1);
        cap_q(32'h0000_0001, 32'h0);
        chk(64'(cap_o.ecx[26]), 64'h1);
        cap_q(32'h0000_000d, 32'h0);
        chk(64'(cap_o.edx[30]), 64'h1);
        chk(64'(cap_o.ecx), 64'(BASE + 32'h80));
        chk(64'(cap_o.ebx), 64'(BASE));
        reg_wr(REG_ENA_HI, 32'h4000_0000);
        cap_q(32'h0000_000d, 32'h0);
        chk(64'(cap_o.ebx), 64'(BASE + 32'h80));
        chk(64'(cap_o.ecx), 64'(BASE + 32'h80));
        cap_q(32'h0000_000d, 32'd62);
        chk(64'(cap_o.eax), 64'h80);
        chk(64'(cap_o.ebx), 64'h340);
        cap_q(32'h8000_001c, 32'h0);
        chk(64'(cap_o.edx[6:5]), 64'h3);
        chk(64'(cap_o.eax[0]), 64'h1);
    endtask

    // core counter frozen by both halt causes, then spacing follows the interval
    task automatic t_core();
        @(posedge sys_clk_i);
        halt_instruction_i <= 1'b1;
        reg_wr(REG_CORE_IVL, 32'h4);
        reg_wr(REG_CTRL, 32'h5);
        repeat (20) @(posedge sys_clk_i);
        reg_rd(REG_CORE_CNT, 32'h4);
        @(posedge sys_clk_i);
        halt_instruction_i <= 1'b0;
        stop_clock_request_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        reg_rd(REG_REF_CNT, 32'h0);
        reg_rd(REG_CORE_CNT, 32'h4);
        chk(64'(n_rec), 64'h0);
        @(posedge sys_clk_i);
        stop_clock_request_i <= 1'b0;
        wait_rec(a);
        chk_rec(8'h05, IP, 64'h0, 32'h0, 16'h0, 1'b1);
        wait_rec(a);
        wait_rec(b);
        chk(64'(b), 64'(a));
        reg_wr(REG_CORE_IVL, 32'h8);
        wait_rec(c);
        wait_rec(c);
        chk(64'(c), 64'(b + 4));
        reg_wr(REG_CTRL, 32'h0);
    endtask

    // reference counter at a quarter of the core rate, timestamps off
    task automatic t_ref();
        reg_wr(REG_REF_RATIO, 32'h4000);
        reg_wr(REG_REF_IVL, 32'h1);
        reg_wr(REG_CTRL, 32'h2);
        wait_rec(a);
        chk_rec(8'h06, IP, 64'h0, 32'h0, 16'h0, 1'b0);
        wait_rec(a);
        reg_wr(REG_REF_IVL, 32'h2);
        wait_rec(b);
        wait_rec(b);
        chk(64'(b), 64'(a + 4));
        reg_wr(REG_CTRL, 32'h4);
    endtask

    // user record in legacy and in long mode
    task automatic t_user(input logic leg);
        @(posedge sys_clk_i);
        legacy_mode_i <= leg;
        user_i <= '{valid: 1'b1, imm: 16'hbeef, rm_value: 32'h1357_9bdf, reg_value: RV,
            ip: 64'h0000_7fff_0000_1230};
        @(posedge sys_clk_i);
        user_i.valid <= 1'b0;
        wait_rec(a);
        chk_rec(8'hff, 64'h0000_7fff_0000_1230, leg ? {32'h0, RV[31:0]} : RV, 32'h1357_9bdf,
            16'hbeef, 1'b1);
    endtask

    // reset, then the scenarios in turn
    initial begin
        n_fail = 0;
        n_tests = 0;
        rstn_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        stop_clock_request_i = 1'b0;
        halt_instruction_i = 1'b0;
        legacy_mode_i = 1'b0;
        instr_ptr_i = IP;
        timestamp_i = TS;
        user_i = '0;
        cap_req_i = 1'b0;
        cap_leaf_i = 32'h0;
        cap_sub_i = 32'h0;
        repeat (12) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_cap();
        t_core();
        t_ref();
        t_user(1'b1);
        t_user(1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
